// File: src/adcf_ctrl.sv
// Digital control of a 12-bit differential ADC: clock, flag, formatting.
// Assumes a same-clock register port and a raw RC clock from a pin.
`timescale 1ns/10ps
`include "adcf_map.svh"

module adcf_ctrl (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register port
  input  wire adcf_pkg::adcf_bus_req_type busReq,
  output logic      [7:0]               rdData,
  // Analog side
  input  wire logic                     rcClkPin,
  input  wire logic [11:0]              sePos,
  input  wire logic [11:0]              diffVal,
  output logic                          convClk,
  output logic                          busy,
  // Core side
  input  wire logic                     deviceSleep,
  input  wire logic                     peripheralIrqEnable,
  input  wire logic                     globalIrqEnable,
  output logic                          irq,
  output logic                          wakeReq,
  output logic                          isrBranch
);

  // Register state
  adcf_pkg::adcf_ctrl_type ctrl_r;
  adcf_pkg::adcf_ctrl_type ctrl_nxt;
  logic [5:0]  convClockDivider_r;
  logic [5:0]  convClockDivider_nxt;
  logic [15:0] resStore_r;
  logic [15:0] resStore_nxt;
  logic        doneFlag_r;
  logic        doneFlag_nxt;
  logic        irqEnable_r;
  logic        irqEnable_nxt;
  logic [7:0]  rdData_r;
  logic [7:0]  rdData_nxt;

  // Clock state
  logic        rcSync1_r;
  logic        rcSync2_r;
  logic        rcSync3_r;
  logic [5:0]  divCnt_r;
  logic [5:0]  divCnt_nxt;
  logic        divClk_r;
  logic        divClk_nxt;

  // Sequencer state
  adcf_pkg::adcf_seq_type seq_r;
  adcf_pkg::adcf_seq_type seq_nxt;
  logic        goPend_r;
  logic        goPend_nxt;
  logic [4:0]  bitCnt_r;
  logic [4:0]  bitCnt_nxt;

  // Derived terms
  logic        rcRise;
  logic        divRise;
  logic        convTick;
  logic        freeze;
  logic        convEnd;
  logic        wrCtrl;
  logic        wrStat;
  logic [15:0] resNew;
  logic [15:0] resView;
  logic [11:0] tcSat;
  logic [11:0] absVal;
  logic [10:0] magSat;
  logic        diffNeg;

  // RC clock from the pin crossed by two flops before any use
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rcSync1_r <= 1'b0;
      rcSync2_r <= 1'b0;
      rcSync3_r <= 1'b0;
    end
    else
    begin
      rcSync1_r <= rcClkPin;
      rcSync2_r <= rcSync1_r;
      rcSync3_r <= rcSync2_r;
    end
  end

  assign rcRise = rcSync2_r & ~rcSync3_r;

  // System-derived source stops in sleep
  assign freeze = deviceSleep & ~ctrl_r.csRc;

  // Divider: half period is divider plus one system clocks
  always_comb
  begin
    divCnt_nxt = divCnt_r;
    divClk_nxt = divClk_r;
    if (!freeze)
    begin
      if (divCnt_r >= convClockDivider_r)
      begin
        divCnt_nxt = 6'h00;
        divClk_nxt = ~divClk_r;
      end
      else
      begin
        divCnt_nxt = divCnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      divCnt_r <= 6'h00;
      divClk_r <= 1'b0;
    end
    else
    begin
      divCnt_r <= divCnt_nxt;
      divClk_r <= divClk_nxt;
    end
  end

  assign divRise = ~freeze & ~divClk_r & (divCnt_r >= convClockDivider_r);

  // Source select picks the clock that steps the sequencer
  assign convTick = ctrl_r.csRc ? rcRise : divRise;
  assign convClk  = ctrl_r.csRc ? rcSync2_r : divClk_r;

  // Bus decode
  assign wrCtrl = busReq.wr & (busReq.addr == `ADCF_OFS_CTRL);
  assign wrStat = busReq.wr & (busReq.addr == `ADCF_OFS_STAT);

  assign convEnd = (seq_r == adcf_pkg::SEQ_CONV) & convTick & goPend_r &
                   ctrl_r.on & (bitCnt_r == `ADCF_CONV_TAD - 5'h01);

  // Sequencer: start request waits for a tick of the selected clock
  always_comb
  begin
    seq_nxt    = seq_r;
    goPend_nxt = goPend_r;
    bitCnt_nxt = bitCnt_r;
    if (wrCtrl)
    begin
      goPend_nxt = busReq.wdata[`ADCF_CTRL_GO] &
                   busReq.wdata[`ADCF_CTRL_ON];
    end
    if (!ctrl_r.on || (wrCtrl && !busReq.wdata[`ADCF_CTRL_GO]))
    begin
      seq_nxt    = adcf_pkg::SEQ_IDLE;
      bitCnt_nxt = 5'h00;
    end
    else if (convTick)
    begin
      unique case (seq_r)
        adcf_pkg::SEQ_IDLE:
        begin
          if (goPend_r)
          begin
            bitCnt_nxt = 5'h00;
            // RC source waits one more period before converting
            seq_nxt = ctrl_r.csRc ? adcf_pkg::SEQ_ARM
                                  : adcf_pkg::SEQ_CONV;
          end
        end
        adcf_pkg::SEQ_ARM:
        begin
          seq_nxt = adcf_pkg::SEQ_CONV;
        end
        adcf_pkg::SEQ_CONV:
        begin
          if (convEnd)
          begin
            seq_nxt    = adcf_pkg::SEQ_IDLE;
            goPend_nxt = 1'b0;
            bitCnt_nxt = 5'h00;
          end
          else
          begin
            bitCnt_nxt = bitCnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_r    <= adcf_pkg::SEQ_IDLE;
      goPend_r <= 1'b0;
      bitCnt_r <= 5'h00;
    end
    else
    begin
      seq_r    <= seq_nxt;
      goPend_r <= goPend_nxt;
      bitCnt_r <= bitCnt_nxt;
    end
  end

  assign busy = goPend_r;

  // Differential saturation to the documented ranges
  assign diffNeg = diffVal[11];
  assign absVal  = diffNeg ? 12'h000 - diffVal : diffVal;
  assign magSat  = (absVal == `ADCF_NEG_MAX) ? 11'(`ADCF_POS_MAX)
                                             : absVal[10:0];

  always_comb
  begin
    tcSat = diffVal;
    if (diffVal == `ADCF_NEG_MAX)
    begin
      tcSat = `ADCF_TC_MIN;
    end
    else if (diffVal == `ADCF_POS_MAX)
    begin
      tcSat = `ADCF_TC_MAX;
    end
  end

  // New result, always held right justified
  always_comb
  begin
    if (!ctrl_r.icDiff)
    begin
      resNew = {4'h0, sePos};
    end
    else if (!ctrl_r.fmt[1])
    begin
      resNew = {{4{tcSat[11]}}, tcSat};
    end
    else
    begin
      resNew = {diffNeg, 4'h0, magSat};
    end
  end

  // Read view applies the justification
  always_comb
  begin
    if (ctrl_r.fmt[0])
    begin
      resView = resStore_r;
    end
    else if (!ctrl_r.icDiff)
    begin
      resView = {resStore_r[11:0], 4'h0};
    end
    else
    begin
      resView = {resStore_r[15], resStore_r[11:0], 3'h0};
    end
  end

  // Register file next values
  always_comb
  begin
    ctrl_nxt             = ctrl_r;
    convClockDivider_nxt = convClockDivider_r;
    resStore_nxt         = resStore_r;
    doneFlag_nxt         = doneFlag_r;
    irqEnable_nxt        = irqEnable_r;
    rdData_nxt           = 8'h00;
    if (busReq.wr)
    begin
      unique case (busReq.addr)
        `ADCF_OFS_CTRL:
        begin
          ctrl_nxt.csRc   = busReq.wdata[`ADCF_CTRL_CS];
          ctrl_nxt.icDiff = busReq.wdata[`ADCF_CTRL_IC];
          ctrl_nxt.fmt    = busReq.wdata[`ADCF_CTRL_FM_HI:
                                         `ADCF_CTRL_FM_LO];
          ctrl_nxt.on     = busReq.wdata[`ADCF_CTRL_ON];
        end
        `ADCF_OFS_DIV:
        begin
          convClockDivider_nxt = busReq.wdata[5:0];
        end
        `ADCF_OFS_RESL:
        begin
          resStore_nxt[7:0] = busReq.wdata;
        end
        `ADCF_OFS_RESH:
        begin
          resStore_nxt[15:8] = busReq.wdata;
        end
        `ADCF_OFS_MASK:
        begin
          irqEnable_nxt = busReq.wdata[`ADCF_STAT_DONE];
        end
        default:
        begin
        end
      endcase
    end
    if (wrStat && busReq.wdata[`ADCF_STAT_DONE])
    begin
      doneFlag_nxt = 1'b0;
    end
    if (convEnd)
    begin
      resStore_nxt = resNew;
      doneFlag_nxt = 1'b1;
    end
    if (busReq.rd)
    begin
      unique case (busReq.addr)
        `ADCF_OFS_CTRL:
        begin
          rdData_nxt = {ctrl_r.on, 2'h0, goPend_r, ctrl_r.fmt,
                        ctrl_r.icDiff, ctrl_r.csRc};
        end
        `ADCF_OFS_DIV:
        begin
          rdData_nxt = {2'h0, convClockDivider_r};
        end
        `ADCF_OFS_RESL:
        begin
          rdData_nxt = resView[7:0];
        end
        `ADCF_OFS_RESH:
        begin
          rdData_nxt = resView[15:8];
        end
        `ADCF_OFS_STAT:
        begin
          rdData_nxt = {7'h00, doneFlag_r};
        end
        `ADCF_OFS_MASK:
        begin
          rdData_nxt = {7'h00, irqEnable_r};
        end
        default:
        begin
          rdData_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r             <= 5'(`ADCF_CTRL_RST);
      convClockDivider_r <= `ADCF_DIV_RST;
      resStore_r         <= `ADCF_RES_RST;
      doneFlag_r         <= 1'b0;
      irqEnable_r        <= 1'b0;
      rdData_r           <= 8'h00;
    end
    else
    begin
      ctrl_r             <= ctrl_nxt;
      convClockDivider_r <= convClockDivider_nxt;
      resStore_r         <= resStore_nxt;
      doneFlag_r         <= doneFlag_nxt;
      irqEnable_r        <= irqEnable_nxt;
      rdData_r           <= rdData_nxt;
    end
  end

  assign rdData = rdData_r;

  // Interrupt, wake and service routine requests
  assign irq       = doneFlag_r & irqEnable_r;
  assign wakeReq   = deviceSleep & irq & peripheralIrqEnable;
  assign isrBranch = irq & peripheralIrqEnable & globalIrqEnable;

endmodule

// File: src/adcf_map.svh
// Offsets, field positions, reset values and counts of the ADC control.
// Assumes an 8-bit register port with a 4-bit byte address.
`ifndef ADCF_MAP_SVH
`define ADCF_MAP_SVH

// Register offsets
`define ADCF_OFS_CTRL 4'h0
`define ADCF_OFS_DIV  4'h1
`define ADCF_OFS_RESL 4'h2
`define ADCF_OFS_RESH 4'h3
`define ADCF_OFS_STAT 4'h4
`define ADCF_OFS_MASK 4'h5

// Control register fields
`define ADCF_CTRL_CS    0
`define ADCF_CTRL_IC    1
`define ADCF_CTRL_FM_LO 2
`define ADCF_CTRL_FM_HI 3
`define ADCF_CTRL_GO    4
`define ADCF_CTRL_ON    7

// Status and mask fields
`define ADCF_STAT_DONE 0

// Reset values
`define ADCF_CTRL_RST 8'h00
`define ADCF_DIV_RST  6'h00
`define ADCF_RES_RST  16'h0000

// Bit periods per conversion
`define ADCF_CONV_TAD 5'h0F

// Signed limits of the differential result
`define ADCF_TC_MIN  12'h801
`define ADCF_TC_MAX  12'h7FE
`define ADCF_NEG_MAX 12'h800
`define ADCF_POS_MAX 12'h7FF

`endif

// File: src/adcf_pkg.sv
// Types shared by the ADC control block.
// Assumes adcf_map.svh for the numeric constants.
package adcf_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARM,
    SEQ_CONV
  } adcf_seq_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adcf_bus_req_type;

  typedef struct packed {
    logic       on;
    logic [1:0] fmt;
    logic       icDiff;
    logic       csRc;
  } adcf_ctrl_type;

endpackage

// File: test/adcf_ctrl_monitor.sv
// Port checker for the ADC control block.
// Assumes it is bound onto adcf_ctrl with one clock.
`timescale 1ns/10ps
`include "adcf_map.svh"
module adcf_ctrl_monitor (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // Register port
  input wire adcf_pkg::adcf_bus_req_type busReq,
  input wire logic [7:0]                 rdData,
  // Converter and core side
  input wire logic                       convClk,
  input wire logic                       busy,
  input wire logic                       deviceSleep,
  input wire logic                       peripheralIrqEnable,
  input wire logic                       globalIrqEnable,
  input wire logic                       irq,
  input wire logic                       wakeReq,
  input wire logic                       isrBranch
);
  logic       csRc;
  logic [5:0] divR;
  logic       wrStat;

  assign wrStat = busReq.wr && busReq.addr == `ADCF_OFS_STAT;

  // Shadow of clock source and divider
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csRc <= 1'b0;
      divR <= 6'h00;
    end
    else if (busReq.wr && busReq.addr == `ADCF_OFS_CTRL)
      csRc <= busReq.wdata[0];
    else if (busReq.wr && busReq.addr == `ADCF_OFS_DIV)
      divR <= busReq.wdata[5:0];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_wake_req: assert property (
    wakeReq == (deviceSleep && irq && peripheralIrqEnable))
    else $error("wake request mismatch");
  chk_isr_branch: assert property (
    isrBranch == (irq && peripheralIrqEnable && globalIrqEnable))
    else $error("service branch mismatch");
  chk_flag_sticky: assert property (
    irq && !wrStat && !(busReq.wr && busReq.addr == `ADCF_OFS_MASK)
    |=> irq) else $error("interrupt dropped on its own");
  chk_flag_clear: assert property (
    wrStat && busReq.wdata[0] && !busy |=> !irq)
    else $error("interrupt not cleared");
  chk_go_busy: assert property (
    busReq.wr && busReq.addr == `ADCF_OFS_CTRL && busReq.wdata[4]
    && busReq.wdata[7] && !busy |=> busy)
    else $error("start not taken");
  chk_sleep_freeze: assert property (
    deviceSleep && !csRc && busy && !busReq.wr |=> $stable(convClk))
    else $error("divided clock ran in sleep");
  chk_div_toggle: assert property (
    (!csRc && divR == 6'h01 && busy && !deviceSleep && !busReq.wr)[*3]
    |-> convClk != $past(convClk, 2)) else $error("divide by four broken");
  chk_rd_idle: assert property (
    !$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data outside window");
endmodule

bind adcf_ctrl adcf_ctrl_monitor mon (
  .clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
  .convClk(convClk), .busy(busy), .deviceSleep(deviceSleep),
  .peripheralIrqEnable(peripheralIrqEnable),
  .globalIrqEnable(globalIrqEnable), .irq(irq), .wakeReq(wakeReq),
  .isrBranch(isrBranch));

// File: test/adcf_ctrl_tb.sv
// Self-checking bench for the ADC control block.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "adcf_map.svh"
module adcf_ctrl_tb;
  logic                       clk, rst, rcClk, convClk, busy;
  logic                       dSleep, pie, global_irq_enable, irq, wakeReq, isrBranch;
  adcf_pkg::adcf_bus_req_type req;
  logic [7:0]                 rdData;
  logic [11:0]                sePos, diffVal;
  logic [15:0]                v;
  logic [31:0]                tbl [0:8];
  int                         nErrors, compares, i;
  time                        t0;

  adcf_ctrl dut (.clk(clk), .rst(rst), .busReq(req), .rdData(rdData),
    .rcClkPin(rcClk), .sePos(sePos), .diffVal(diffVal),
    .convClk(convClk), .busy(busy), .deviceSleep(dSleep),
    .peripheralIrqEnable(pie), .globalIrqEnable(global_irq_enable), .irq(irq),
    .wakeReq(wakeReq), .isrBranch(isrBranch));

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Free running oscillator pin, unrelated phase
  initial
  begin
    rcClk = 0;
    forever #21 rcClk = ~rcClk;
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    begin
      compares++;
      if (g !== e)
      begin
        nErrors++;
        $display("Error %0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
    end
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    begin
      @(posedge clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdData;
    end
  endtask

  task rres(output logic [15:0] r);
    begin
      rd(`ADCF_OFS_RESH, r[15:8]);
      rd(`ADCF_OFS_RESL, r[7:0]);
    end
  endtask

  task wdone;
    int n;
    begin
      n = 0;
      repeat (2) @(posedge clk);
      #1;
      while (busy !== 1'b0 && n < 3000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk({15'h0, busy}, 16'h0000);
    end
  endtask

  task conv(input logic [3:0] c);
    begin
      wr(`ADCF_OFS_CTRL, {4'h8, c});
      wr(`ADCF_OFS_CTRL, {4'h9, c});
      wdone;
    end
  endtask

  task end_of_test;
    begin
      $display("Errors %0d compares %0d", nErrors, compares);
      if (nErrors == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    nErrors++;
    end_of_test;
  end

  initial
  begin
    rst = 1;
    req = '0;
    sePos = 12'hABC;
    diffVal = 12'h000;
    dSleep = 0;
    pie = 0;
    global_irq_enable = 0;
    nErrors = 0;
    compares = 0;
    // Control nibble, difference input, expected result view
    tbl = '{32'h4FFE0ABC, 32'h0FFEABC0, 32'h6FFEFFFE, 32'h2FFEFFF0,
      32'hEFFE8002, 32'hAFFE8010, 32'h6800F801, 32'h67FF07FE,
      32'hE80087FF};
    repeat (2) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 7; i++)
    begin
      rd(i == 6 ? 4'hF : 4'(i), v[7:0]);
      chk({8'h00, v[7:0]}, 16'h0000);
    end
    // Divided clock periods at the largest and a small code
    for (i = 0; i < 2; i++)
    begin
      wr(`ADCF_OFS_DIV, i ? 8'h01 : 8'h3F);
      wr(`ADCF_OFS_CTRL, 8'h80);
      wr(`ADCF_OFS_CTRL, 8'h90);
      @(posedge convClk);
      @(posedge convClk);
      t0 = $time;
      @(posedge convClk);
      chk(16'(($time - t0) / 8), i ? 16'h0004 : 16'h0080);
      wdone;
    end
    wr(`ADCF_OFS_DIV, 8'h01);
    for (i = 0; i < 9; i++)
    begin
      diffVal <= tbl[i][27:16];
      conv(tbl[i][31:28]);
      rres(v);
      chk(v, tbl[i][15:0]);
    end
    rd(`ADCF_OFS_STAT, v[7:0]);
    chk({8'h00, v[7:0]}, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    wr(`ADCF_OFS_MASK, 8'h01);
    repeat (50) @(posedge clk);
    dSleep <= 1;
    pie <= 1;
    @(posedge clk);
    #1 chk({13'h0, irq, wakeReq, isrBranch}, 16'h0006);
    @(posedge clk);
    global_irq_enable <= 1;
    @(posedge clk);
    #1 chk({14'h0, wakeReq, isrBranch}, 16'h0003);
    wr(`ADCF_OFS_STAT, 8'h01);
    rd(`ADCF_OFS_STAT, v[7:0]);
    chk({7'h00, irq, v[7:0]}, 16'h0000);
    // System clock source stalls in sleep
    wr(`ADCF_OFS_CTRL, 8'h80);
    wr(`ADCF_OFS_CTRL, 8'h90);
    repeat (100) @(posedge clk);
    #1 chk({15'h0, busy}, 16'h0001);
    @(posedge clk);
    dSleep <= 0;
    wdone;
    wr(`ADCF_OFS_STAT, 8'h01);
    @(posedge clk);
    dSleep <= 1;
    conv(4'h1);
    #1 chk({14'h0, wakeReq, isrBranch}, 16'h0003);
    @(posedge clk);
    dSleep <= 0;
    // Software writes land right justified
    wr(`ADCF_OFS_CTRL, 8'h82);
    wr(`ADCF_OFS_RESL, 8'h34);
    wr(`ADCF_OFS_RESH, 8'h12);
    rres(v);
    chk(v, 16'h11A0);
    wr(`ADCF_OFS_CTRL, 8'h86);
    rres(v);
    chk(v, 16'h1234);
    end_of_test;
  end
endmodule
